// file: hdl/dbp_map.vh
`ifndef DBP_MAP_VH
`define DBP_MAP_VH
// data register selections
`define DBP_SEL_PART_ID      8'h00
`define DBP_SEL_REV_ID       8'h01
`define DBP_SEL_PROG_CTL     8'h02
`define DBP_SEL_PROG_DATA    8'hB4
`define DBP_SEL_PART_ID_ALT  8'hFD
`define DBP_SEL_REV_ID_ALT   8'hFE
// reset values
`define DBP_SELECT_RESET     8'h00
`define DBP_PROG_CTL_RESET   8'h00
`define DBP_PROG_DATA_RESET  8'h00
// enable key codes
`define DBP_KEY_FIRST        8'h02
`define DBP_KEY_SECOND       8'h01
// flash command codes
`define DBP_CMD_BLOCK_READ   8'h06
`define DBP_CMD_BLOCK_WRITE  8'h07
`define DBP_CMD_PAGE_ERASE   8'h08
`define DBP_CMD_DEVICE_ERASE 8'h03
// frame opcodes (2 bits, lsb first)
`define DBP_OP_DATA_READ     2'h0
`define DBP_OP_ADDR_WRITE    2'h1
`define DBP_OP_DATA_WRITE    2'h2
`define DBP_OP_ADDR_READ     2'h3
// link timing
`define DBP_RESET_LOW_NS     20000
`define DBP_CLK_PERIOD_NS    5
`define DBP_RESET_LOW_CYC    ((`DBP_RESET_LOW_NS+`DBP_CLK_PERIOD_NS-1)/`DBP_CLK_PERIOD_NS)
`endif

// file: hdl/dbp_sync.v
`timescale 1ns/1ps
// three-stage synchroniser; output changes once stages two and three agree
module dbp_sync (
  input  wire i_clk,
  input  wire i_reset,
  input  wire i_async,
  output reg  o_level
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // shift chain and agreement filter
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      s3_reg  <= 1'b1;
      o_level <= 1'b1;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        o_level <= s3_reg;
    end
  end
endmodule

// file: hdl/dbp_prog_unlock.v
`timescale 1ns/1ps
`include "dbp_map.vh"
// watches control writes for the ordered two-code key
module dbp_prog_unlock (
  input  wire       i_clk,
  input  wire       i_reset,
  input  wire       i_wr,
  input  wire [7:0] i_data,
  output reg        o_enabled
);
  reg first_seen_reg;

  // sequence detector; enable sticks until system reset
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      first_seen_reg <= 1'b0;
      o_enabled      <= 1'b0;
    end else if (i_wr && !o_enabled) begin
      if (first_seen_reg && i_data == `DBP_KEY_SECOND) begin
        o_enabled      <= 1'b1;
        first_seen_reg <= 1'b0;
      end else begin
        // any other write restarts; a fresh first code re-arms
        first_seen_reg <= (i_data == `DBP_KEY_FIRST);
      end
    end
  end
endmodule

// file: hdl/dbp_port.v
`timescale 1ns/1ps
`include "dbp_map.vh"
module dbp_port #(
  parameter [7:0]         PART_ID     = 8'h5A, // arbitrary value
  parameter [7:0]         REVISION_ID = 8'h0C, // arbitrary value
  parameter integer       RESET_LOW_CYC = `DBP_RESET_LOW_CYC
) (
  input  wire       i_clk,
  input  wire       i_reset,
  input  wire       i_debug_clock_pin,
  input  wire       i_debug_data_pin,
  output reg        o_debug_data_pin,
  output reg        o_debug_data_oe,
  output reg        o_prog_enabled,
  output reg        o_hold_normal,
  output reg        o_link_reset,
  output reg  [7:0] o_flash_cmd,
  output reg        o_flash_cmd_valid
);
  // frame states
  localparam [2:0] ST_START = 3'h0;
  localparam [2:0] ST_INS   = 3'h1;
  localparam [2:0] ST_WDATA = 3'h2;
  localparam [2:0] ST_TURN  = 3'h3;
  localparam [2:0] ST_WAIT  = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [2:0] ST_STOP  = 3'h6;

  wire       ck_sync;
  wire       dat_sync;
  wire       prog_en;
  reg        ck_prev_reg;
  reg  [2:0] state_reg;
  reg  [1:0] op_reg;
  reg  [2:0] bit_reg;
  reg  [7:0] shift_reg;
  reg  [7:0] select_reg;
  reg  [7:0] prog_data_reg;
  reg        data_first_reg;
  reg        ctl_wr_reg;
  reg  [7:0] ctl_wdata_reg;
  reg  [15:0] low_cnt_reg;

  // read mux over the selected data register
  function [7:0] dbp_read;
    input [7:0] sel;
    input [7:0] pdat;
    input       en;
    begin
      case (sel)
        `DBP_SEL_PART_ID, `DBP_SEL_PART_ID_ALT:
          dbp_read = PART_ID;
        `DBP_SEL_REV_ID, `DBP_SEL_REV_ID_ALT:
          dbp_read = REVISION_ID;
        `DBP_SEL_PROG_CTL:
          dbp_read = {7'h00, en};
        `DBP_SEL_PROG_DATA:
          dbp_read = pdat;
        default:
          dbp_read = 8'h00;
      endcase
    end
  endfunction

  dbp_sync u_ck_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_debug_clock_pin),
    .o_level (ck_sync)
  );

  dbp_sync u_dat_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_debug_data_pin),
    .o_level (dat_sync)
  );

  dbp_prog_unlock u_unlock (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_wr      (ctl_wr_reg),
    .i_data    (ctl_wdata_reg),
    .o_enabled (prog_en)
  );

  wire ck_rise = ck_sync && !ck_prev_reg; // device samples on rising edge
  wire ck_fall = !ck_sync && ck_prev_reg; // device drives after falling edge

  // long clock-low detection resets the link
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      low_cnt_reg  <= 16'h0000;
      o_link_reset <= 1'b0;
    end else if (ck_sync) begin
      low_cnt_reg  <= 16'h0000;
      o_link_reset <= 1'b0;
    end else if (low_cnt_reg == RESET_LOW_CYC[15:0]) begin
      o_link_reset <= 1'b1;
    end else begin
      low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
  end

  // frame engine driven from debug clock edges
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ck_prev_reg       <= 1'b1;
      state_reg         <= ST_START;
      op_reg            <= 2'h0;
      bit_reg           <= 3'h0;
      shift_reg         <= 8'h00;
      select_reg        <= `DBP_SELECT_RESET;
      prog_data_reg     <= `DBP_PROG_DATA_RESET;
      data_first_reg    <= 1'b1;
      ctl_wr_reg        <= 1'b0;
      ctl_wdata_reg     <= `DBP_PROG_CTL_RESET;
      o_debug_data_pin  <= 1'b0;
      o_debug_data_oe   <= 1'b0;
      o_flash_cmd       <= 8'h00;
      o_flash_cmd_valid <= 1'b0;
    end else begin
      ck_prev_reg       <= ck_sync;
      ctl_wr_reg        <= 1'b0;
      o_flash_cmd_valid <= 1'b0;
      if (o_link_reset) begin
        state_reg       <= ST_START;
        o_debug_data_oe <= 1'b0;
      end else if (ck_rise) begin
        case (state_reg)
          ST_START: begin
            bit_reg   <= 3'h0;
            state_reg <= ST_INS;
          end
          ST_INS: begin
            op_reg[bit_reg[0]] <= dat_sync;
            bit_reg <= 3'h0;
            if (bit_reg[0]) begin
              if ({dat_sync, op_reg[0]} == `DBP_OP_ADDR_WRITE ||
                  {dat_sync, op_reg[0]} == `DBP_OP_DATA_WRITE)
                state_reg <= ST_WDATA;
              else if ({dat_sync, op_reg[0]} == `DBP_OP_ADDR_READ) begin
                // no turnaround bit: select goes out on the next bit
                shift_reg <= select_reg;
                state_reg <= ST_RDATA;
              end else
                state_reg <= ST_WAIT;
            end else begin
              bit_reg <= 3'h1;
            end
          end
          ST_WDATA: begin
            shift_reg <= {dat_sync, shift_reg[7:1]};
            bit_reg   <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              state_reg <= (op_reg == `DBP_OP_DATA_WRITE) ? ST_WAIT
                                                          : ST_STOP;
              if (op_reg == `DBP_OP_ADDR_WRITE) begin
                select_reg     <= {dat_sync, shift_reg[7:1]};
                data_first_reg <= 1'b1; // reselect starts a new command
              end
            end
          end
          ST_WAIT: begin
            // ready after one wait bit, which the device drives high
            begin
              bit_reg <= 3'h0;
              if (op_reg == `DBP_OP_DATA_WRITE) begin
                state_reg <= ST_STOP;
                if (select_reg == `DBP_SEL_PROG_CTL) begin
                  ctl_wr_reg    <= 1'b1;
                  ctl_wdata_reg <= shift_reg;
                end else if (select_reg == `DBP_SEL_PROG_DATA &&
                             prog_en) begin
                  prog_data_reg <= shift_reg;
                  if (data_first_reg) begin
                    o_flash_cmd       <= shift_reg;
                    o_flash_cmd_valid <= 1'b1;
                  end
                  data_first_reg <= 1'b0;
                end
              end else begin
                shift_reg <= dbp_read(select_reg, prog_data_reg, prog_en);
                state_reg <= ST_RDATA;
              end
            end
          end
          ST_TURN: begin
            shift_reg <= select_reg;
            bit_reg   <= 3'h0;
            state_reg <= ST_RDATA;
          end
          ST_RDATA: begin
            bit_reg   <= bit_reg + 3'h1;
            shift_reg <= {1'b0, shift_reg[7:1]};
            if (bit_reg == 3'h7)
              state_reg <= ST_STOP;
          end
          ST_STOP: begin
            o_debug_data_oe <= 1'b0;
            state_reg       <= ST_START;
          end
          default: state_reg <= ST_START;
        endcase
      end else if (ck_fall) begin
        // drive read bits and the ready bit from the falling edge on, held through the high phase
        o_debug_data_pin <= (state_reg == ST_WAIT) ? 1'b1 : shift_reg[0];
        o_debug_data_oe  <= (state_reg == ST_RDATA) ||
                            (state_reg == ST_WAIT);
      end
      if (select_reg != `DBP_SEL_PROG_DATA)
        data_first_reg <= 1'b1; // new command after reselect
    end
  end

  // status outputs
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_prog_enabled <= 1'b0;
      o_hold_normal  <= 1'b0;
    end else begin
      o_prog_enabled <= prog_en;
      o_hold_normal  <= prog_en;
    end
  end
endmodule

// file: test/dbp_port_properties.sv
`timescale 1ns/1ps
// watches status and data drive of the debug port
module dbp_port_properties #(
  parameter integer RESET_LOW_CYC = 4000
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_debug_clock_pin,
  input wire o_debug_data_pin,
  input wire o_debug_data_oe,
  input wire o_prog_enabled,
  input wire o_hold_normal,
  input wire o_link_reset,
  input wire o_flash_cmd_valid
);
  int low_cnt;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // length of the current link clock low phase
  always @(posedge i_clk or posedge i_reset)
    if (i_reset) low_cnt <= 0;
    else low_cnt <= i_debug_clock_pin ? 0 : low_cnt + 1;
  sequence link_high8;
    i_debug_clock_pin [*8];
  endsequence
  chk_hold_eq:
    assert property (o_hold_normal == o_prog_enabled) else $error("hold");
  chk_enable_sticky:
    assert property (o_prog_enabled |=> o_prog_enabled) else $error("lost");
  chk_release_quiet:
    assert property ($fell(i_reset) |-> !(o_prog_enabled || o_link_reset
      || o_debug_data_oe || o_flash_cmd_valid)) else $error("busy");
  chk_cmd_pulse:
    assert property (o_flash_cmd_valid |=> !o_flash_cmd_valid)
      else $error("long pulse");
  chk_cmd_locked:
    assert property (o_flash_cmd_valid |-> o_prog_enabled)
      else $error("locked cmd");
  chk_drive_still:
    assert property (link_high8 ##0 o_debug_data_oe
      |-> $stable(o_debug_data_pin)) else $error("drive moved");
  chk_lrst_rise:
    assert property (low_cnt >= RESET_LOW_CYC + 6 |-> o_link_reset)
      else $error("no link reset");
  chk_lrst_early:
    assert property (low_cnt > 0 && low_cnt < RESET_LOW_CYC |-> !o_link_reset)
      else $error("early link reset");
endmodule
bind dbp_port dbp_port_properties #(.RESET_LOW_CYC(RESET_LOW_CYC)) chk_u (
  .i_clk(i_clk), .i_reset(i_reset), .i_debug_clock_pin(i_debug_clock_pin),
  .o_debug_data_pin(o_debug_data_pin), .o_debug_data_oe(o_debug_data_oe),
  .o_prog_enabled(o_prog_enabled), .o_hold_normal(o_hold_normal),
  .o_link_reset(o_link_reset), .o_flash_cmd_valid(o_flash_cmd_valid)
);

// file: test/dbp_host.sv
`timescale 1ns/1ps
// host programmer: owns the link clock, shares the data wire
module dbp_host (
  input  wire i_clk,
  input  wire i_dev_d,
  input  wire i_dev_oe,
  output reg  o_ck = 1'b1,
  output wire o_wire
);
  reg drv = 1'b0;
  reg hoe = 1'b0;
  reg last = 1'b0;
  // released wire keeps changing level
  assign o_wire = i_dev_oe ? i_dev_d : hoe ? drv : ~last;
  always @(posedge i_clk) last <= o_wire;
  // link clock held at one level for n cycles
  task ck_set(input logic v, input int n);
    @(posedge i_clk);
    o_ck <= v;
    repeat (n) @(posedge i_clk);
  endtask
  // drive on the low half, sample before the rise
  task bitx(input logic v, input logic h, output logic s);
    drv <= v;
    hoe <= h;
    ck_set(1'b0, 12);
    s = o_wire;
    ck_set(1'b1, 11);
  endtask
  // start, opcode, write byte, wait, read byte, stop
  task frame(input [1:0] op, input [7:0] wd, output [7:0] rd,
             output logic ok);
    logic s;
    int   i;
    rd = 8'h00;
    bitx(1'b0, 1'b0, s);
    for (i = 0; i < 2; i++) bitx(op[i], 1'b1, s);
    for (i = 0; i < 8 && op[0] != op[1]; i++) bitx(wd[i], 1'b1, s);
    s = op[0];
    for (i = 0; i < 40 && !s; i++) bitx(1'b0, 1'b0, s);
    ok = s;
    for (i = 0; i < 8 && op[0] == op[1]; i++) begin
      bitx(1'b0, 1'b0, s);
      rd[i] = s;
    end
    bitx(1'b0, 1'b0, s);
  endtask
endmodule

// file: test/tb_dbp_port.sv
`timescale 1ns/1ps
// register traffic through the host model
module tb_dbp_port;
  localparam [7:0] PID = 8'h5A; // arbitrary value
  localparam [7:0] RID = 8'h0C; // arbitrary value
  reg        i_clk = 1'b0;
  reg        i_reset = 1'b1;
  wire       ck, dw, dd, doe, pen, hold, lrst, cval;
  wire [7:0] cmd;
  reg  [7:0] rd, lcmd;
  reg        ok;
  int        error_cnt = 0, check_count = 0, ncmd = 0, k;
  reg  [7:0] cmds [4] = '{8'h06, 8'h07, 8'h08, 8'h03};
  always #2.5 i_clk = ~i_clk;
  dbp_port #(.PART_ID(PID), .REVISION_ID(RID), .RESET_LOW_CYC(40)) dut_u (
    .i_clk(i_clk), .i_reset(i_reset), .i_debug_clock_pin(ck),
    .i_debug_data_pin(dw), .o_debug_data_pin(dd), .o_debug_data_oe(doe),
    .o_prog_enabled(pen), .o_hold_normal(hold), .o_link_reset(lrst),
    .o_flash_cmd(cmd), .o_flash_cmd_valid(cval));
  dbp_host host_u (.i_clk(i_clk), .i_dev_d(dd), .i_dev_oe(doe),
    .o_ck(ck), .o_wire(dw));
  // record each command byte handed on
  always @(posedge i_clk)
    if (cval === 1'b1) begin
      lcmd <= cmd;
      ncmd <= ncmd + 1;
    end
  task check(input [7:0] s, input [7:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task complete_run;
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one frame; a wait that never ends closes the run
  task xf(input [1:0] op, input [7:0] wd);
    host_u.frame(op, wd, rd, ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    xf(2'h1, a);
    xf(2'h2, v);
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    xf(2'h1, a);
    xf(2'h0, 8'h00);
    check(rd, e);
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clk);
    xf(2'h0, 8'h00);
    check(rd, PID);
    wr(8'h00, 8'hA5);
    rdc(8'h00, PID);
    rdc(8'hFD, PID);
    rdc(8'h01, RID);
    rdc(8'hFE, RID);
    xf(2'h3, 8'h00);
    check(rd, 8'hFE);
    rdc(8'h77, 8'h00);
    rdc(8'h02, 8'h00);
    wr(8'hB4, 8'h08);
    check(ncmd[7:0], 8'h00);
    wr(8'h02, 8'h01);
    xf(2'h2, 8'h02);
    xf(2'h2, 8'h03);
    xf(2'h2, 8'h01);
    rdc(8'h02, 8'h00);
    xf(2'h2, 8'h02);
    xf(2'h2, 8'h01);
    rdc(8'h02, 8'h01);
    check({6'h0, pen, hold}, 8'h03);
    xf(2'h2, 8'h00);
    for (k = 0; k < 4; k++) begin
      wr(8'hB4, cmds[k]);
      check(lcmd, cmds[k]);
    end
    check(ncmd[7:0], 8'h04);
    host_u.ck_set(1'b0, 50);
    check({6'h0, lrst, pen}, 8'h03);
    host_u.ck_set(1'b1, 12);
    check({6'h0, lrst, pen}, 8'h01);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clk);
    check({7'h0, pen}, 8'h00);
    rdc(8'h02, 8'h00);
    complete_run();
  end
endmodule
